// *** hw/cfe_fault_confine.sv ***
// CAN error detection, fault confinement and emergency field builder.
// Assumes sampled bus bits arrive on the clk domain with a bit strobe from
// the bit timing logic, and frame position flags from the protocol engine.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Emergency bytes four to eight hold local code and four parameters.
// - Fatal island failure: code 01, island state and global bits lo/hi.
// - Island state exception: code 02, same parameter layout.
// - Island bus error passive: code 03, state and global bits.
// - Island module emergency: code 05, node id then three zeros.
// - Configuration software owns outputs: code 06, zero parameters.
// - Guarding or heartbeat failure: code 82, zero parameters.
// - Too short process data object: code 83, zero parameters.
// - Transmitter compares driven and read arbitration bits; bit error.
// - Stuff opposite bit after five equal bits; receivers drop it.
// - Six equal bits in stuffed region raise a stuff error.
// - Wrong fixed-format field value raises a form error.
// - Correct receiver drives dominant in acknowledge slot.
// - Transmitter reading recessive acknowledge raises acknowledge error.
// - Fifteen-bit CRC appended; receivers recompute and flag mismatch.
// - First detector sends active or passive error flag; frame dropped.
// - Receive error counter adds one per receive error.
// - Transmit error counter adds eight per transmit error.
// - Error-free traffic decrements the matching counter.
// - Counter above 127 enters error passive; passive flags only.
// - Passive node returns to active when counters fall back.
// - Transmit counter above 255 enters bus-off until intervention.
// - Emergency message is exactly eight data bytes.
// - Clearing error sends emergency with error code 0000.
module cfe_fault_confine #(
   parameter int ADDR_W = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   // Bit level view of the bus
   input wire logic bitStrobe,
   input wire logic rxBit,
   input wire logic txBit,
   input wire logic txActive,
   input wire logic inArb,
   input wire logic inStuffed,
   input wire logic ackSlot,
   input wire logic fixedField,
   input wire logic fixedExpect,
   input wire logic crcStart,
   input wire logic crcShift,
   input wire logic crcCheck,
   input wire logic [14:0] crcRx,
   input wire logic frameOkRx,
   input wire logic frameOkTx,
   // Emergency sources
   input wire cfe_pkg::cfe_event_t evIn,
   input wire logic [7:0] islNodeId,
   input wire logic emcyAck,
   // Register port
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   // Bus side outputs
   output logic stuffReq,
   output logic ackDrive,
   output logic errFlagReq,
   output logic errFlagPassive,
   output logic busOff,
   output logic [14:0] crcOut,
   output logic frameDiscard,
   output logic emcyValid,
   output cfe_pkg::cfe_emcy_t emcyMsg
);

   // Stuff and CRC state
   logic lastBit_q, lastBit_d;
   logic [2:0] runLen_q, runLen_d;
   logic [14:0] crc_q, crc_d;
   logic stuffReq_q, stuffReq_d;
   logic ackDrive_q, ackDrive_d;
   cfe_pkg::cfe_bus_ev_t busEv_q, busEv_d;
   // Confinement state
   logic [8:0] rec_q, rec_d;
   logic [8:0] tec_q, tec_d;
   cfe_pkg::cfe_conf_t conf_q, conf_d;
   logic errFlag_q, errFlag_d;
   logic discard_q, discard_d;
   logic errPassive_q, errPassive_d;
   logic busOff_q, busOff_d;
   // Emergency state
   cfe_pkg::cfe_emcy_t emcy_q, emcy_d;
   logic emcyValid_q, emcyValid_d;
   cfe_pkg::cfe_event_t pend_q, pend_d;
   // Registers
   logic [31:0] ctrl_q, ctrl_d;
   logic [15:0] islState_q, islState_d;
   logic [15:0] global_q, global_d;
   logic [31:0] rdata_q, rdata_d;
   logic rxErr, txErr;

   // CRC-15 step over one unstuffed bit
   function automatic logic [14:0] crcStep(input logic [14:0] c,
                                           input logic b);
      logic fb;
      fb = b ^ c[14];
      crcStep = {c[13:0], 1'b0} ^ (fb ? 15'h4599 : 15'h0000);
   endfunction : crcStep

   // Counter decrement held at zero
   function automatic logic [8:0] decSat(input logic [8:0] v);
      decSat = (v == cfe_pkg::CNT_RESET) ? v : v - 9'h001;
   endfunction : decSat

   // Bit monitoring, stuffing, form, acknowledge and CRC checks
   always_comb begin
      lastBit_d = lastBit_q;
      runLen_d = runLen_q;
      crc_d = crc_q;
      stuffReq_d = 1'b0;
      ackDrive_d = 1'b0;
      busEv_d = '0;
      busEv_d.isTx = txActive;
      busEv_d.okRx = frameOkRx;
      busEv_d.okTx = frameOkTx;
      if (crcStart) begin
         crc_d = 15'h0000;
         runLen_d = 3'h0;
      end else if (bitStrobe && conf_q != cfe_pkg::BUS_OFF) begin
         if (txActive && inArb && txBit != rxBit) begin
            busEv_d.bitErr = 1'b1;
         end
         if (inStuffed) begin
            if (rxBit == lastBit_q && runLen_q == cfe_pkg::STUFF_RUN) begin
               busEv_d.stuffErr = 1'b1;
            end else if (runLen_q == cfe_pkg::STUFF_RUN) begin
               runLen_d = 3'h1; // Stuff bit removed, not fed to CRC
            end else begin
               runLen_d = (rxBit == lastBit_q) ? runLen_q + 3'h1 : 3'h1;
               if (crcShift) begin
                  crc_d = crcStep(crc_q, rxBit);
               end
               if (runLen_d == cfe_pkg::STUFF_RUN && txActive) begin
                  stuffReq_d = 1'b1;
               end
            end
         end
         if (fixedField && rxBit != fixedExpect) begin
            busEv_d.formErr = 1'b1;
         end
         if (ackSlot && txActive && rxBit) begin
            busEv_d.ackErr = 1'b1;
         end
         if (crcCheck && !txActive && crc_q != crcRx) begin
            busEv_d.crcErr = 1'b1;
         end
         lastBit_d = rxBit;
      end
      if (ackSlot && !txActive && crcCheck && crc_q == crcRx
          && conf_q != cfe_pkg::BUS_OFF) begin
         ackDrive_d = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lastBit_q <= 1'b1;
         runLen_q <= 3'h0;
         crc_q <= 15'h0000;
         stuffReq_q <= 1'b0;
         ackDrive_q <= 1'b0;
         busEv_q <= '0;
      end else begin
         lastBit_q <= lastBit_d;
         runLen_q <= runLen_d;
         crc_q <= crc_d;
         stuffReq_q <= stuffReq_d;
         ackDrive_q <= ackDrive_d;
         busEv_q <= busEv_d;
      end
   end

   // Classify detected errors by direction
   assign rxErr = !busEv_q.isTx && (busEv_q.stuffErr || busEv_q.formErr
                  || busEv_q.crcErr || busEv_q.bitErr);
   assign txErr = busEv_q.isTx && (busEv_q.stuffErr || busEv_q.formErr
                  || busEv_q.ackErr || busEv_q.bitErr);

   // Error counters and confinement state
   always_comb begin
      rec_d = rec_q;
      tec_d = tec_q;
      conf_d = conf_q;
      errFlag_d = 1'b0;
      discard_d = 1'b0;
      if (conf_q == cfe_pkg::BUS_OFF) begin
         if (ctrl_q[0]) begin // Software recovery from bus-off
            rec_d = cfe_pkg::CNT_RESET;
            tec_d = cfe_pkg::CNT_RESET;
            conf_d = cfe_pkg::ERR_ACTIVE;
         end
      end else begin
         if (rxErr) begin
            rec_d = (rec_q == 9'h1ff) ? rec_q
                    : rec_q + cfe_pkg::REC_STEP;
         end else if (busEv_q.okRx) begin
            rec_d = decSat(rec_q);
         end
         if (txErr) begin
            tec_d = tec_q + cfe_pkg::TEC_STEP;
            if (tec_q > 9'h1f7) begin
               tec_d = 9'h1ff;
            end
         end else if (busEv_q.okTx) begin
            tec_d = decSat(tec_q);
         end
         if (rxErr || txErr) begin
            errFlag_d = 1'b1;
            discard_d = 1'b1;
         end
         if (tec_d > cfe_pkg::BUSOFF_LIMIT) begin
            conf_d = cfe_pkg::BUS_OFF;
         end else if (rec_d > cfe_pkg::PASSIVE_LIMIT
                      || tec_d > cfe_pkg::PASSIVE_LIMIT) begin
            conf_d = cfe_pkg::ERR_PASSIVE;
         end else begin
            conf_d = cfe_pkg::ERR_ACTIVE;
         end
      end
      // Flag kind follows the state in which the error was detected
      errPassive_d = errFlag_d && (conf_q == cfe_pkg::ERR_PASSIVE);
      busOff_d = (conf_d == cfe_pkg::BUS_OFF);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rec_q <= cfe_pkg::CNT_RESET;
         tec_q <= cfe_pkg::CNT_RESET;
         conf_q <= cfe_pkg::ERR_ACTIVE;
         errFlag_q <= 1'b0;
         discard_q <= 1'b0;
         errPassive_q <= 1'b0;
         busOff_q <= 1'b0;
      end else begin
         rec_q <= rec_d;
         tec_q <= tec_d;
         conf_q <= conf_d;
         errFlag_q <= errFlag_d;
         discard_q <= discard_d;
         errPassive_q <= errPassive_d;
         busOff_q <= busOff_d;
      end
   end

   // Emergency message builder; pending events latch until sent
   always_comb begin
      cfe_pkg::cfe_event_t pn;
      pn = pend_q | evIn;
      emcy_d = emcy_q;
      emcyValid_d = emcyValid_q;
      if (emcyValid_q && emcyAck) begin
         emcyValid_d = 1'b0;
      end
      if (!emcyValid_q || emcyAck) begin
         emcy_d = '0; // Eight bytes, zero parameters by default
         emcy_d.errCode = 16'hff00;
         emcy_d.errReg = 8'h81;
         if (pn.islFatal) begin
            emcy_d.localCode = cfe_pkg::CODE_ISL_FATAL;
            pn.islFatal = 1'b0;
         end else if (pn.islExcept) begin
            emcy_d.localCode = cfe_pkg::CODE_ISL_EXCEPT;
            pn.islExcept = 1'b0;
         end else if (pn.islPassive) begin
            emcy_d.localCode = cfe_pkg::CODE_ISL_PASSIVE;
            pn.islPassive = 1'b0;
         end else if (pn.islEmcy) begin
            emcy_d.localCode = cfe_pkg::CODE_ISL_EMCY;
            emcy_d.par1 = islNodeId;
            pn.islEmcy = 1'b0;
         end else if (pn.cfgOutputs) begin
            emcy_d.localCode = cfe_pkg::CODE_CFG_OUTPUTS;
            pn.cfgOutputs = 1'b0;
         end else if (pn.guardFail) begin
            emcy_d.localCode = cfe_pkg::CODE_GUARD;
            emcy_d.errReg = 8'h11;
            pn.guardFail = 1'b0;
         end else if (pn.shortPdo) begin
            emcy_d.localCode = cfe_pkg::CODE_SHORT_PDO;
            pn.shortPdo = 1'b0;
         end else if (pn.recovered) begin
            emcy_d.errCode = cfe_pkg::EMCY_RECOVERY;
            emcy_d.errReg = cfe_pkg::BYTE_ZERO;
            emcy_d.localCode = cfe_pkg::BYTE_ZERO;
            pn.recovered = 1'b0;
         end
         if (emcy_d.localCode == cfe_pkg::CODE_ISL_FATAL
             || emcy_d.localCode == cfe_pkg::CODE_ISL_EXCEPT
             || emcy_d.localCode == cfe_pkg::CODE_ISL_PASSIVE) begin
            emcy_d.par1 = islState_q[7:0];
            emcy_d.par2 = islState_q[15:8];
            emcy_d.par3 = global_q[7:0];
            emcy_d.par4 = global_q[15:8];
         end
         emcyValid_d = (pn != (pend_q | evIn));
         if (!emcyValid_d) begin
            emcy_d = emcy_q;
         end
      end
      pend_d = pn;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         emcy_q <= '0;
         emcyValid_q <= 1'b0;
         pend_q <= '0;
      end else begin
         emcy_q <= emcy_d;
         emcyValid_q <= emcyValid_d;
         pend_q <= pend_d;
      end
   end

   // Register port: writes and one-cycle-late reads
   always_comb begin
      ctrl_d = ctrl_q;
      ctrl_d[0] = 1'b0; // Bus-off restart is a self-clearing pulse
      islState_d = islState_q;
      global_d = global_q;
      rdata_d = 32'h0000_0000;
      if (regWr) begin
         unique case (regAddr)
            cfe_pkg::REG_CTRL: ctrl_d = regWdata;
            cfe_pkg::REG_ISL_STATE: islState_d = regWdata[15:0];
            cfe_pkg::REG_GLOBAL: global_d = regWdata[15:0];
            default: ;
         endcase
      end
      if (regRd) begin
         unique case (regAddr)
            cfe_pkg::REG_CTRL: rdata_d = ctrl_q;
            cfe_pkg::REG_STATUS: rdata_d = {29'h0, emcyValid_q,
                                            conf_q};
            cfe_pkg::REG_COUNTERS: rdata_d = {7'h0, tec_q, 7'h0, rec_q};
            cfe_pkg::REG_ISL_STATE: rdata_d = {16'h0, islState_q};
            cfe_pkg::REG_GLOBAL: rdata_d = {16'h0, global_q};
            cfe_pkg::REG_EMCY_LO: rdata_d = emcy_q[63:32];
            cfe_pkg::REG_EMCY_HI: rdata_d = emcy_q[31:0];
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl_q <= cfe_pkg::CTRL_RESET;
         islState_q <= 16'h0000;
         global_q <= 16'h0000;
         rdata_q <= 32'h0000_0000;
      end else begin
         ctrl_q <= ctrl_d;
         islState_q <= islState_d;
         global_q <= global_d;
         rdata_q <= rdata_d;
      end
   end

   // Outputs straight from flip-flops
   assign regRdata = rdata_q;
   assign stuffReq = stuffReq_q;
   assign ackDrive = ackDrive_q;
   assign errFlagReq = errFlag_q;
   assign errFlagPassive = errPassive_q;
   assign busOff = busOff_q;
   assign crcOut = crc_q;
   assign frameDiscard = discard_q;
   assign emcyValid = emcyValid_q;
   assign emcyMsg = emcy_q;

endmodule : cfe_fault_confine
`default_nettype wire

// *** hw/cfe_pkg.sv ***
// Package for the CAN fault confinement and emergency field block.
// Assumes one 10 MHz clock domain; shared by the block and its bench.
package cfe_pkg;
   // Local error codes placed in the fourth data byte
   localparam logic [7:0] CODE_ISL_FATAL = 8'h01;
   localparam logic [7:0] CODE_ISL_EXCEPT = 8'h02;
   localparam logic [7:0] CODE_ISL_PASSIVE = 8'h03;
   localparam logic [7:0] CODE_ISL_EMCY = 8'h05;
   localparam logic [7:0] CODE_CFG_OUTPUTS = 8'h06;
   localparam logic [7:0] CODE_GUARD = 8'h82;
   localparam logic [7:0] CODE_SHORT_PDO = 8'h83;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   // Emergency error code announcing recovery
   localparam logic [15:0] EMCY_RECOVERY = 16'h0000;
   // Error counter steps and thresholds
   localparam logic [8:0] REC_STEP = 9'h001;
   localparam logic [8:0] TEC_STEP = 9'h008;
   localparam logic [8:0] PASSIVE_LIMIT = 9'h07f;
   localparam logic [8:0] BUSOFF_LIMIT = 9'h0ff;
   localparam logic [8:0] CNT_RESET = 9'h000;
   // Bit stuffing run length
   localparam logic [2:0] STUFF_RUN = 3'h5;
   // Register offsets of the plain register port
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h1;
   localparam logic [3:0] REG_COUNTERS = 4'h2;
   localparam logic [3:0] REG_ISL_STATE = 4'h3;
   localparam logic [3:0] REG_GLOBAL = 4'h4;
   localparam logic [3:0] REG_EMCY_LO = 4'h5;
   localparam logic [3:0] REG_EMCY_HI = 4'h6;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // Fault confinement states
   typedef enum logic [1:0] {
      ERR_ACTIVE,
      ERR_PASSIVE,
      BUS_OFF
   } cfe_conf_t;

   // Emergency event requests, one bit each
   typedef struct packed {
      logic islFatal;
      logic islExcept;
      logic islPassive;
      logic islEmcy;
      logic cfgOutputs;
      logic guardFail;
      logic shortPdo;
      logic recovered;
   } cfe_event_t;

   // Error detection events from the bit engine
   typedef struct packed {
      logic bitErr;
      logic stuffErr;
      logic formErr;
      logic ackErr;
      logic crcErr;
      logic isTx;
      logic okRx;
      logic okTx;
   } cfe_bus_ev_t;

   // Eight-byte emergency message
   typedef struct packed {
      logic [15:0] errCode;
      logic [7:0] errReg;
      logic [7:0] localCode;
      logic [7:0] par1;
      logic [7:0] par2;
      logic [7:0] par3;
      logic [7:0] par4;
   } cfe_emcy_t;
endpackage : cfe_pkg

// *** verification/cfe_bus_peer.sv ***
// Model of the other nodes on the wired bus, dominant level is 0.
// Assumes the line rests recessive through its pull-up when released.
`timescale 1ns/1ps
`default_nettype none
module cfe_bus_peer (
   input wire logic txBit,
   input wire logic txActive,
   input wire logic ackDrive,
   input wire logic ackSlot,
   input wire logic peerDrive,
   input wire logic peerBit,
   input wire logic peerAck,
   output logic rxBit
);
   // Wired-AND of all drivers on the line
   always_comb begin
      rxBit = 1'b1;
      if (txActive && !txBit) rxBit = 1'b0;
      if (ackDrive) rxBit = 1'b0;
      if (peerDrive && !peerBit) rxBit = 1'b0;
      if (peerAck && ackSlot) rxBit = 1'b0;
   end
endmodule : cfe_bus_peer
`default_nettype wire

// *** verification/cfe_fault_props.sv ***
// Checker for the fault confinement and emergency block.
// Assumes it is bound to cfe_fault_confine and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module cfe_fault_props #(
   parameter int ADDR_W = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic bitStrobe,
   input wire logic rxBit,
   input wire logic txBit,
   input wire logic txActive,
   input wire logic inArb,
   input wire logic ackSlot,
   input wire logic fixedField,
   input wire logic fixedExpect,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic stuffReq,
   input wire logic ackDrive,
   input wire logic errFlagReq,
   input wire logic errFlagPassive,
   input wire logic busOff,
   input wire logic emcyValid,
   input wire logic emcyAck,
   input wire cfe_pkg::cfe_emcy_t emcyMsg
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Detected faults on a sampled bit
   sequence s_bitErr;
      bitStrobe && txActive && inArb && !busOff && txBit != rxBit;
   endsequence
   sequence s_ackErr;
      bitStrobe && txActive && ackSlot && rxBit && !busOff;
   endsequence
   sequence s_formErr;
      bitStrobe && fixedField && !busOff && rxBit != fixedExpect;
   endsequence
   sequence s_flag;
      ##[1:3] errFlagReq;
   endsequence
   // Each of these faults is flagged one to three cycles later
   property p_bitErr;
      s_bitErr |-> s_flag;
   endproperty
   a_bitErr: assert property (p_bitErr)
      else $error("bit error unflagged");
   property p_ackErr;
      s_ackErr |-> s_flag;
   endproperty
   a_ackErr: assert property (p_ackErr)
      else $error("ack error unflagged");
   property p_formErr;
      s_formErr |-> s_flag;
   endproperty
   a_formErr: assert property (p_formErr)
      else $error("form error unflagged");
   property p_passive;
      errFlagPassive |-> errFlagReq;
   endproperty
   a_passive: assert property (p_passive)
      else $error("lone passive flag");
   // Emergency message held whole until taken
   property p_hold;
      emcyValid && !emcyAck |=> emcyValid && $stable(emcyMsg);
   endproperty
   a_hold: assert property (p_hold)
      else $error("message not held");
   property p_zeroPar;
      emcyValid && (emcyMsg.localCode inside {8'h06, 8'h82, 8'h83})
         |-> {emcyMsg.par1, emcyMsg.par2, emcyMsg.par3, emcyMsg.par4} == 0;
   endproperty
   a_zeroPar: assert property (p_zeroPar)
      else $error("nonzero params");
   property p_nodePar;
      emcyValid && emcyMsg.localCode == 8'h05
         |-> {emcyMsg.par2, emcyMsg.par3, emcyMsg.par4} == 0;
   endproperty
   a_nodePar: assert property (p_nodePar)
      else $error("node params");
   // Bus-off is silent and lasts until the restart write
   property p_offQuiet;
      busOff |-> !stuffReq && !ackDrive;
   endproperty
   a_offQuiet: assert property (p_offQuiet)
      else $error("bus-off active");
   property p_offStay;
      busOff && !($past(regWr) && $past(regWdata[0])
         && $past(regAddr) == ADDR_W'(cfe_pkg::REG_CTRL)) |=> busOff;
   endproperty
   a_offStay: assert property (p_offStay)
      else $error("bus-off left");
endmodule : cfe_fault_props
bind cfe_fault_confine cfe_fault_props #(.ADDR_W(ADDR_W)) u_props (.*);
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking bench for the fault confinement and emergency block.
// Assumes the peer model closes the bus loop and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk, rst_n, bitStrobe, txBit, txActive, inArb, inStuffed, ackSlot;
   logic fixedField, fixedExpect, crcStart, crcShift, crcCheck, frameOkRx;
   logic frameOkTx, emcyAck, regWr, regRd, stuffReq, ackDrive, errFlagReq;
   logic errFlagPassive, busOff, frameDiscard, emcyValid, rxBit;
   logic peerDrive, peerBit, peerAck;
   logic [14:0] crcRx, crcOut;
   logic [7:0] islNodeId;
   logic [3:0] regAddr;
   logic [31:0] regWdata, regRdata, d;
   cfe_pkg::cfe_event_t evIn;
   cfe_pkg::cfe_emcy_t emcyMsg;
   int n_fail, tests_run, nFlag, nPass, nStuff, nAck, nDisc;

   cfe_fault_confine u_dut (.*);
   cfe_bus_peer u_peer (.*);

   // Clock at 100 ns period
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Tally of pulses seen on the block's outputs
   always @(posedge clk) begin
      nFlag += (errFlagReq === 1'b1);
      nPass += (errFlagPassive === 1'b1);
      nStuff += (stuffReq === 1'b1);
      nAck += (ackDrive === 1'b1);
      nDisc += (frameDiscard === 1'b1);
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   task automatic rd(input logic [3:0] a, output logic [31:0] q);
      @(posedge clk) regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk) regRd <= 1'b0;
      #1 q = regRdata;
   endtask : rd

   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk) regWr <= 1'b1;
      regAddr <= a;
      regWdata <= v;
      @(posedge clk) regWr <= 1'b0;
   endtask : wr

   // One sampled bus bit, then room for the flag to appear
   task automatic bitOnce;
      @(posedge clk) bitStrobe <= 1'b1;
      @(posedge clk) bitStrobe <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : bitOnce

   task automatic okPulse(input logic tx);
      @(posedge clk) frameOkTx <= tx;
      frameOkRx <= !tx;
      @(posedge clk) frameOkTx <= 1'b0;
      frameOkRx <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : okPulse

   task automatic startFrame;
      @(posedge clk) crcStart <= 1'b1;
      @(posedge clk) crcStart <= 1'b0;
      @(posedge clk);
      chk(crcOut, 32'h0);
   endtask : startFrame

   task automatic t_idle;
      okPulse(1'b0);
      okPulse(1'b1);
      rd(cfe_pkg::REG_COUNTERS, d);
      chk(d, 32'h0);
      rd(4'hf, d);
      chk(d, 32'h0);
      chk(busOff, 32'h0);
   endtask : t_idle

   task automatic t_tx;
      txActive <= 1'b1;
      ackSlot <= 1'b1;
      peerAck <= 1'b1;
      bitOnce();
      chk(nFlag, 32'h0);
      peerAck <= 1'b0;
      bitOnce();
      rd(cfe_pkg::REG_COUNTERS, d);
      chk(d, 32'h0008_0000);
      okPulse(1'b1);
      rd(cfe_pkg::REG_COUNTERS, d);
      chk(d, 32'h0007_0000);
      ackSlot <= 1'b0;
      inArb <= 1'b1;
      peerDrive <= 1'b1;
      for (int i = 1; i <= 32; i++) begin
         bitOnce();
         if (i == 15 || i == 16) begin
            rd(cfe_pkg::REG_STATUS, d);
            chk(d, i - 15);
            chk(nPass, 32'h0);
         end
      end
      chk(nFlag, 33);
      chk(nPass >= 15, 32'h1);
      chk(busOff, 32'h1);
      bitOnce();
      chk(nFlag, 33);
      wr(cfe_pkg::REG_CTRL, 32'h1);
      repeat (2) @(posedge clk);
      #1 chk(busOff, 32'h0);
      txActive <= 1'b0;
      inArb <= 1'b0;
      peerDrive <= 1'b0;
   endtask : t_tx

   task automatic t_rx;
      fixedField <= 1'b1;
      fixedExpect <= 1'b1;
      peerDrive <= 1'b1;
      repeat (128) bitOnce();
      rd(cfe_pkg::REG_COUNTERS, d);
      chk(d[8:0], 32'h80);
      rd(cfe_pkg::REG_STATUS, d);
      chk(d, 32'h1);
      fixedField <= 1'b0;
      peerDrive <= 1'b0;
      okPulse(1'b0);
      rd(cfe_pkg::REG_COUNTERS, d);
      chk(d[8:0], 32'h7f);
      rd(cfe_pkg::REG_STATUS, d);
      chk(d, 32'h0);
   endtask : t_rx

   task automatic t_crc;
      int f0, a0;
      f0 = nFlag;
      inStuffed <= 1'b1;
      crcShift <= 1'b1;
      bitOnce();
      chk(crcOut != 15'h0000, 32'h1);
      inStuffed <= 1'b0;
      crcShift <= 1'b0;
      startFrame();
      crcCheck <= 1'b1;
      bitOnce();
      chk(nFlag, f0);
      a0 = nAck;
      ackSlot <= 1'b1;
      bitOnce();
      ackSlot <= 1'b0;
      crcCheck <= 1'b0;
      chk(nAck > a0, 32'h1);
      startFrame();
      a0 = nDisc;
      crcCheck <= 1'b1;
      crcRx <= 15'h0001;
      bitOnce();
      chk(nFlag, f0 + 1);
      chk(nDisc > a0, 32'h1);
      a0 = nAck;
      ackSlot <= 1'b1;
      bitOnce();
      ackSlot <= 1'b0;
      crcCheck <= 1'b0;
      chk(nAck, a0);
   endtask : t_crc

   task automatic t_stuff;
      int f0, s0;
      startFrame();
      txActive <= 1'b1;
      txBit <= 1'b0;
      inStuffed <= 1'b1;
      f0 = nFlag;
      s0 = nStuff;
      repeat (5) bitOnce();
      chk(nStuff, s0 + 1);
      bitOnce();
      chk(nFlag, f0 + 1);
      txActive <= 1'b0;
      txBit <= 1'b1;
      inStuffed <= 1'b0;
   endtask : t_stuff

   task automatic t_emcy;
      logic [7:0] code [8];
      logic [31:0] par;
      code = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h82, 8'h83, 8'h00};
      wr(cfe_pkg::REG_ISL_STATE, 32'h0000_c3b4);
      wr(cfe_pkg::REG_GLOBAL, 32'h0000_d6e5);
      for (int i = 0; i < 8; i++) begin
         par = (i < 3) ? 32'hb4c3_e5d6 : ((i == 3) ? 32'h2c00_0000 : 32'h0);
         @(posedge clk) evIn <= 8'h80 >> i;
         @(posedge clk) evIn <= 8'h00;
         #1;
         for (int k = 0; k < 10 && emcyValid !== 1'b1; k++) begin
            @(posedge clk);
            #1;
         end
         chk(emcyMsg.localCode, code[i]);
         chk({emcyMsg.par1, emcyMsg.par2, emcyMsg.par3, emcyMsg.par4},
            par);
         chk(emcyMsg.errCode, (i == 7) ? 16'h0 : 16'hff00);
         @(posedge clk) emcyAck <= 1'b1;
         @(posedge clk) emcyAck <= 1'b0;
         @(posedge clk);
         #1 chk(emcyValid, 32'h0);
      end
   endtask : t_emcy

   task automatic results;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : results

   // Main sequence: reset for four cycles, then each scenario in turn
   initial begin
      rst_n = 1'b0;
      {bitStrobe, txActive, inArb, inStuffed, ackSlot, fixedField} = '0;
      {fixedExpect, crcStart, crcShift, crcCheck, frameOkRx, frameOkTx} = '0;
      {emcyAck, regWr, regRd, peerDrive, peerBit, peerAck} = '0;
      txBit = 1'b1;
      crcRx = 15'h0000;
      islNodeId = 8'h2c;
      regAddr = 4'h0;
      regWdata = 32'h0;
      evIn = '0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_idle();
      t_tx();
      t_rx();
      t_crc();
      t_stuff();
      t_emcy();
      results();
   end

   // Watchdog far beyond the twelve hundred or so cycles the run needs
   initial begin
      #2000000;
      n_fail++;
      results();
   end
endmodule : testbench
`default_nettype wire
